//--- design/ebw_pkg.sv
// package: register map, field layout, reset values and width codes of the
// area-pair bus width select block.
// assumes: apb slave with 32-bit data, byte addresses, aligned words.
package ebw_pkg;

  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h004;

  // bus_width_config field positions
  localparam int PAIR04_SIZE_BIT = 0;
  localparam int PAIR15_SIZE_BIT = 1;
  localparam int PAIR26_SIZE_BIT = 2;
  localparam int PAIR37_SIZE_BIT = 3;
  localparam int PAIR04_LONG_BIT = 4;
  localparam int PAIR15_LONG_BIT = 5;
  localparam int PAIR26_LONG_BIT = 6;
  localparam int PAIR37_LONG_BIT = 7;
  localparam int CFG_W = 16;

  // size bits reset to word, long bits to zero
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h000f;
  // long bits as a mask, used to hold them at zero in the narrow variant
  localparam logic [CFG_W-1:0] LONG_MASK = 16'h00f0;

  // status layout: two bits of width per pair, then the rom enable level
  localparam int STAT_ROM_BIT = 8;

  // decoded width codes handed to the access sequencer
  typedef enum logic [1:0] {
    EBW_W8,
    EBW_W16,
    EBW_W32
  } ebw_width_t;

endpackage

//--- design/ebw_width_dec.sv
// holds: decoder from one area pair's long and size bits to a bus width.
// assumes: the caller has already forced long to zero where it is not allowed.
`timescale 1ns/10ps
module ebw_width_dec (
  input wire logic long_sel,
  input wire logic size_sel,
  output ebw_pkg::ebw_width_t width
);

  always_comb begin
    if (long_sel) begin
      width = ebw_pkg::EBW_W32;
    end else if (size_sel) begin
      width = ebw_pkg::EBW_W16;
    end else begin
      width = ebw_pkg::EBW_W8;
    end
  end

endmodule // ebw_width_dec

//--- design/ebw_bus_width.sv
// holds: area-pair bus width select register with apb access and the decoded
// width given to the external access sequencer.
// assumes: one clock, synchronous active-high reset, inputs synchronous to clk.
//
// Function
// - pair 2/6: long bit gives 32 bits
// - pair 1/5: long bit gives 32 bits
// - pair 0/4 rom on: long bit gives 32 bits
// - pair 0/4 uses mode pins when rom off
// - narrow variant: long bits reserved, read zero
// - pair 3/7 long clear: size picks 8/16
// - pair 3/7 long set: size ignored, 32
// - pair 2/6 long clear: size picks 8/16
// - pair 2/6 long set: size ignored, 32
// - pair 1/5 long clear: size picks 8/16
// - pair 0/4 rom on, long clear: 8/16
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module ebw_bus_width #(
  parameter bit HAS_LONG_BUS = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ebw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rom_enabled,
  input wire logic [1:0] mode_bus_width,
  input wire logic [2:0] acc_area,
  output ebw_pkg::ebw_width_t acc_width
);

  // refused at elaboration: only the two documented variants exist
  if (HAS_LONG_BUS !== 1'b0 && HAS_LONG_BUS !== 1'b1) begin : g_bad_variant
    $error("HAS_LONG_BUS must be 0 or 1");
  end

  // apb decode
  logic setup_phase;
  logic access_phase;
  logic hit_cfg;
  logic hit_stat;
  logic mapped;
  logic [ebw_pkg::CFG_W-1:0] cfg_reg;
  logic [ebw_pkg::CFG_W-1:0] cfg_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  ebw_pkg::ebw_width_t acc_width_reg;
  ebw_pkg::ebw_width_t acc_width_next;
  ebw_pkg::ebw_width_t pair_width [4];
  ebw_pkg::ebw_width_t mode_width;
  logic [31:0] stat_word;
  logic [ebw_pkg::CFG_W-1:0] allowed_mask;
  logic [ebw_pkg::CFG_W-1:0] wr_mask;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_cfg = (paddr == ebw_pkg::CFG_OFFSET);
  assign hit_stat = (paddr == ebw_pkg::STAT_OFFSET);
  assign mapped = hit_cfg || hit_stat;

  // no wait states: read data is caught in the setup cycle
  assign pready = access_phase;
  assign pslverr = access_phase && (!mapped || (pwrite && hit_stat));
  assign prdata = prdata_reg;
  assign acc_width = acc_width_reg;

  // the narrow variant masks the long bits out of cfg_next every cycle, so a stray
  // write of one cannot leak into the sequencer
  assign allowed_mask = HAS_LONG_BUS ? 16'hffff : ~ebw_pkg::LONG_MASK;
  assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & 16'h00ff & allowed_mask;

  always_comb begin
    cfg_next = cfg_reg;
    if (access_phase && pwrite && hit_cfg) begin
      cfg_next = (cfg_reg & ~wr_mask) | (pwdata[ebw_pkg::CFG_W-1:0] & wr_mask);
    end
    cfg_next = cfg_next & allowed_mask;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= ebw_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // per-pair decode; pair 0/4 long bit only counts with rom enabled
  ebw_width_dec u_dec04 (
    .long_sel(cfg_reg[ebw_pkg::PAIR04_LONG_BIT] && rom_enabled),
    .size_sel(cfg_reg[ebw_pkg::PAIR04_SIZE_BIT]),
    .width(pair_width[0])
  );
  ebw_width_dec u_dec15 (
    .long_sel(cfg_reg[ebw_pkg::PAIR15_LONG_BIT]),
    .size_sel(cfg_reg[ebw_pkg::PAIR15_SIZE_BIT]),
    .width(pair_width[1])
  );
  ebw_width_dec u_dec26 (
    .long_sel(cfg_reg[ebw_pkg::PAIR26_LONG_BIT]),
    .size_sel(cfg_reg[ebw_pkg::PAIR26_SIZE_BIT]),
    .width(pair_width[2])
  );
  ebw_width_dec u_dec37 (
    .long_sel(cfg_reg[ebw_pkg::PAIR37_LONG_BIT]),
    .size_sel(cfg_reg[ebw_pkg::PAIR37_SIZE_BIT]),
    .width(pair_width[3])
  );

  // mode pins carry the width code directly; the unused code falls back to 8, as does the 32 code on the narrow variant
  always_comb begin
    case (mode_bus_width)
      2'h1: mode_width = ebw_pkg::EBW_W16;
      2'h2: mode_width = HAS_LONG_BUS ? ebw_pkg::EBW_W32 : ebw_pkg::EBW_W8;
      default: mode_width = ebw_pkg::EBW_W8;
    endcase
  end

  // areas n and n+4 share a pair, so the low two area bits select it
  always_comb begin
    acc_width_next = pair_width[acc_area[1:0]];
    if (acc_area[1:0] == 2'h0 && !rom_enabled) begin
      acc_width_next = mode_width;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_width_reg <= ebw_pkg::EBW_W16;
    end else begin
      acc_width_reg <= acc_width_next;
    end
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[1:0] = rom_enabled ? pair_width[0] : mode_width;
    stat_word[3:2] = pair_width[1];
    stat_word[5:4] = pair_width[2];
    stat_word[7:6] = pair_width[3];
    stat_word[ebw_pkg::STAT_ROM_BIT] = rom_enabled;
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase && !pwrite) begin
      if (hit_cfg) begin
        prdata_next = {16'h0000, cfg_reg & allowed_mask};
      end else if (hit_stat) begin
        prdata_next = stat_word;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // checks
  a_pair26_long_w32: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h2 && cfg_reg[ebw_pkg::PAIR26_LONG_BIT]) |=> acc_width == ebw_pkg::EBW_W32)
    else $error("pair 2/6 long set but width not 32");

  a_pair15_long_w32: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h1 && cfg_reg[ebw_pkg::PAIR15_LONG_BIT]) |=> acc_width == ebw_pkg::EBW_W32)
    else $error("pair 1/5 long set but width not 32");

  a_pair04_long_w32: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h0 && rom_enabled && cfg_reg[ebw_pkg::PAIR04_LONG_BIT])
      |=> acc_width == ebw_pkg::EBW_W32)
    else $error("pair 0/4 long set with rom on but width not 32");

  a_pair04_mode_pins: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h0 && !rom_enabled && mode_bus_width == 2'h1) |=> acc_width == ebw_pkg::EBW_W16)
    else $error("pair 0/4 with rom off does not follow mode pins");

  a_narrow_long_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !HAS_LONG_BUS |-> ((cfg_reg & ebw_pkg::LONG_MASK) == 16'h0000
      && (!(access_phase && !pwrite && hit_cfg) || prdata[7:4] == 4'h0)))
    else $error("long bit visible in narrow variant");

  a_pair37_size_sel: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h3 && !cfg_reg[ebw_pkg::PAIR37_LONG_BIT])
      |=> acc_width == ($past(cfg_reg[ebw_pkg::PAIR37_SIZE_BIT]) ? ebw_pkg::EBW_W16 : ebw_pkg::EBW_W8))
    else $error("pair 3/7 width does not follow size bit");

  a_pair37_long_w32: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h3 && cfg_reg[ebw_pkg::PAIR37_LONG_BIT]) |=> acc_width == ebw_pkg::EBW_W32)
    else $error("pair 3/7 long set but width not 32");

  a_pair26_size_sel: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h2 && !cfg_reg[ebw_pkg::PAIR26_LONG_BIT])
      |=> acc_width == ($past(cfg_reg[ebw_pkg::PAIR26_SIZE_BIT]) ? ebw_pkg::EBW_W16 : ebw_pkg::EBW_W8))
    else $error("pair 2/6 width does not follow size bit");

  a_pair26_size_ign: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h2 && cfg_reg[ebw_pkg::PAIR26_LONG_BIT] && !cfg_reg[ebw_pkg::PAIR26_SIZE_BIT])
      |=> acc_width == ebw_pkg::EBW_W32)
    else $error("pair 2/6 size bit not ignored with long set");

  a_pair15_size_sel: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h1 && !cfg_reg[ebw_pkg::PAIR15_LONG_BIT])
      |=> acc_width == ($past(cfg_reg[ebw_pkg::PAIR15_SIZE_BIT]) ? ebw_pkg::EBW_W16 : ebw_pkg::EBW_W8))
    else $error("pair 1/5 width does not follow size bit");

  a_pair04_size_sel: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_area[1:0] == 2'h0 && rom_enabled && !cfg_reg[ebw_pkg::PAIR04_LONG_BIT])
      |=> acc_width == ($past(cfg_reg[ebw_pkg::PAIR04_SIZE_BIT]) ? ebw_pkg::EBW_W16 : ebw_pkg::EBW_W8))
    else $error("pair 0/4 with rom on does not follow size bit");

  a_new_width_next: assert property (@(posedge clk) disable iff (sys_rst)
    (access_phase && pwrite && hit_cfg && pstrb[0] && pwdata[3:0] == 4'h0
      && (pwdata[7:4] & {4{HAS_LONG_BUS}}) == 4'h0)
      ##1 (acc_area[1:0] == 2'h3) |=> acc_width == ebw_pkg::EBW_W8)
    else $error("new width not used on next access");

endmodule // ebw_bus_width

//--- tb/ebw_mem_model.sv
// holds: external memory on the chip-select areas, reporting the byte lanes it serves.
// assumes: width code straight from the block, one access per cycle.
`timescale 1ns/10ps
module ebw_mem_model (
  input wire clk,
  input wire ebw_pkg::ebw_width_t acc_width,
  output logic [2:0] lanes
);
  // lanes beyond the width are left undriven by the memory, so only the count matters
  always_comb begin
    lanes = (acc_width == ebw_pkg::EBW_W32) ? 3'h4 : (acc_width == ebw_pkg::EBW_W16) ? 3'h2 : 3'h1;
  end
endmodule // ebw_mem_model

//--- tb/external_area_bus_width_select_test.sv
// holds: self-checking bench for the bus width block, wide and narrow variants side by side.
// assumes: apb slave with no wait states; memory model on the wide width output.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module external_area_bus_width_select_test;
  typedef struct {logic err; logic rd; logic [31:0] d1; logic [31:0] d2;} ebw_note_t;
  logic clk, sys_rst, psel, penable, pwrite, pready, pready_n, pslverr, pslverr_n, rom_enabled, chk_w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata_n, pwdata_n;
  logic [1:0] mode_bus_width;
  logic [2:0] acc_area, lanes;
  ebw_pkg::ebw_width_t acc_width, acc_width_n;
  int error_cnt = 0;
  int n_tests = 0;
  ebw_note_t nq[$];
  logic [3:0] wq[$];
  ebw_note_t nt;
  logic [3:0] we;
  // software keeps the long bits at zero on the narrow part
  assign pwdata_n = pwdata & ~{16'h0000, ebw_pkg::LONG_MASK};
  ebw_bus_width #(.HAS_LONG_BUS(1'b1)) DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_enabled(rom_enabled), .mode_bus_width(mode_bus_width), .acc_area(acc_area),
    .acc_width(acc_width));
  ebw_bus_width #(.HAS_LONG_BUS(1'b0)) DUT_NARROW (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata_n), .pstrb(4'hf), .prdata(prdata_n), .pready(pready_n),
    .pslverr(pslverr_n), .rom_enabled(rom_enabled), .mode_bus_width(mode_bus_width), .acc_area(acc_area),
    .acc_width(acc_width_n));
  ebw_mem_model MEM (.clk(clk), .acc_width(acc_width), .lanes(lanes));
  always #2 clk = ~clk;
  function automatic logic [1:0] exp_w(logic [7:0] c, logic [2:0] a, logic r, logic [1:0] m, bit wide);
    if (a[1:0] == 2'h0 && !r) return (m == 2'h1) ? 2'h1 : (m == 2'h2 && wide) ? 2'h2 : 2'h0;
    if (c[ebw_pkg::PAIR04_LONG_BIT + a[1:0]] && wide) return 2'h2;
    return c[a[1:0]] ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [31:0] exp_stat(logic [7:0] c, logic r, logic [1:0] m, bit wide);
    return {23'h00_0000, r, exp_w(c, 3'h3, r, m, wide), exp_w(c, 3'h2, r, m, wide), exp_w(c, 3'h1, r, m, wide),
            exp_w(c, 3'h0, r, m, wide)};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] e1, input logic [31:0] e2);
    nq.push_back('{err, !wr, e1, e2});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && nq.size() > 0) begin
      nt = nq.pop_front();
      `CHK("pslverr", nt.err, pslverr)
      `CHK("pslverr_narrow", nt.err, pslverr_n)
      `CHK("pready_narrow", 1'b1, pready_n)
      if (nt.rd) begin
        `CHK("cfg", nt.d1, prdata)
        `CHK("cfg_narrow", nt.d2, prdata_n)
      end
    end
    if (chk_w && wq.size() > 0) begin
      we = wq.pop_front();
      `CHK("acc_width", we[3:2], acc_width)
      `CHK("acc_width_narrow", we[1:0], acc_width_n)
      `CHK("lanes", (we[3:2] == 2'h2) ? 3'h4 : (we[3:2] == 2'h1) ? 3'h2 : 3'h1, lanes)
    end
  end
  initial begin
    #(4 * 20000);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [7:0] c;
    logic r;
    logic [1:0] m;
    {clk, sys_rst, psel, penable, pwrite, rom_enabled, chk_w} = 7'b0100000;
    {paddr, pwdata, mode_bus_width, acc_area} = '0;
    void'($urandom(32'hb22b_6727));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, ebw_pkg::CFG_OFFSET, 32'h0000_0000, 1'b0, 32'h0000_000f, 32'h0000_000f);
    apb(1'b0, 12'h008, 32'h0000_0000, 1'b1, 32'h0000_0000, 32'h0000_0000);
    apb(1'b1, ebw_pkg::STAT_OFFSET, 32'h0000_00ff, 1'b1, 32'h0000_0000, 32'h0000_0000);
    // a fresh all-zero config must reach the very next access to pair 3/7
    apb(1'b1, ebw_pkg::CFG_OFFSET, 32'h0000_0000, 1'b0, 32'h0000_0000, 32'h0000_0000);
    acc_area <= 3'h3;
    wq.push_back(4'h0);
    @(posedge clk);
    chk_w <= 1'b1;
    @(posedge clk);
    chk_w <= 1'b0;
    $display("test reset and refusals done");
    for (int i = 0; i < 40; i++) begin
      c = 8'($urandom());
      r = 1'($urandom());
      m = 2'($urandom());
      apb(1'b1, ebw_pkg::CFG_OFFSET, {24'h0000_00, c}, 1'b0, 32'h0000_0000, 32'h0000_0000);
      apb(1'b0, ebw_pkg::CFG_OFFSET, 32'h0000_0000, 1'b0, {24'h0000_00, c}, {28'h0000_000, c[3:0]});
      rom_enabled <= r;
      mode_bus_width <= m;
      for (int a = 0; a < 8; a++) begin
        acc_area <= 3'(a);
        wq.push_back({exp_w(c, 3'(a), r, m, 1'b1), exp_w(c, 3'(a), r, m, 1'b0)});
        @(posedge clk);
        chk_w <= 1'b1;
        @(posedge clk);
        chk_w <= 1'b0;
      end
      apb(1'b0, ebw_pkg::STAT_OFFSET, 32'h0000_0000, 1'b0, exp_stat(c, r, m, 1'b1), exp_stat(c, r, m, 1'b0));
    end
    $display("test width sweep done");
    summarize();
  end
endmodule // external_area_bus_width_select_test
